// ==== core/sers_consts.vh ====
// Constants for the supply enable and reset sequencer.
// Assumes a 100 MHz core clock standing in for the internal RC oscillator.
`ifndef SERS_CONSTS_VH
`define SERS_CONSTS_VH
`define SERS_CLK_MHZ 100
`define SERS_BLANK_US 150
`define SERS_BLANK_CYC (`SERS_BLANK_US * `SERS_CLK_MHZ)
`define SERS_BLANK_W 15
// Last count of the blanking window, one below SERS_BLANK_CYC, sized for the counter.
`define SERS_BLANK_LAST 15'h3a97
`define SERS_LEVEL_W 4
`define SERS_UV_W 3
`define SERS_TARGET_W 7
`define SERS_LEVEL_RST 4'h0
`define SERS_UV_RST 3'h0
`define SERS_UV_OFF 3'h0
`define SERS_TARGET_RST 7'h00
`define SERS_ST_RESET 2'h0
`define SERS_ST_BLANK 2'h1
`define SERS_ST_RUN 2'h2
`endif

// ==== core/sers_sequencer.v ====
// Supply enable, chip reset and gate-drive undervoltage lockout sequencing.
// Assumes all inputs synchronous to core_clk; rst is the power-on reset monitor output.
`timescale 1ns/1ps
`include "sers_consts.vh"

module sers_sequencer (
  input wire core_clk,
  input wire rst,
  input wire clk_en,
  input wire wake_input_one,
  input wire wake_input_two,
  input wire cfg_wr,
  input wire [`SERS_LEVEL_W-1:0] cfg_level,
  input wire [`SERS_UV_W-1:0] cfg_uv_level,
  input wire cfg_keep_on,
  input wire cfg_boost_en,
  input wire [`SERS_TARGET_W-1:0] cfg_target,
  input wire gate_supply_low_raw,
  output reg core_supply_en,
  output reg chip_in_reset,
  output reg uv_blank_active,
  output reg gate_supply_uv,
  output reg booster_run,
  output reg [`SERS_LEVEL_W-1:0] gate_supply_level_sel,
  output reg [`SERS_UV_W-1:0] gate_supply_uv_level,
  output reg core_supply_keep_on,
  output reg [`SERS_TARGET_W-1:0] boost_target_level
);

  ////////////////////////////////////////////////////////////////////////////
  // State codes, registers and the conditions that steer them.

  localparam [1:0] ST_RESET = `SERS_ST_RESET;
  localparam [1:0] ST_BLANK = `SERS_ST_BLANK;
  localparam [1:0] ST_RUN = `SERS_ST_RUN;

  reg [1:0] state_q;
  reg [1:0] state_d;
  reg [`SERS_BLANK_W-1:0] blank_cnt_q;
  reg [`SERS_BLANK_W-1:0] blank_cnt_d;
  reg boost_en_q;
  reg boost_en_d;
  reg core_supply_en_d;
  reg chip_in_reset_d;
  reg uv_blank_active_d;
  reg gate_supply_uv_d;
  reg booster_run_d;
  reg [`SERS_LEVEL_W-1:0] level_d;
  reg [`SERS_UV_W-1:0] uv_level_d;
  reg keep_on_d;
  reg [`SERS_TARGET_W-1:0] target_d;
  wire wake_any;
  wire stay_on;
  wire uv_hit;
  wire in_reset_st;
  wire in_blank_st;
  wire in_run_st;
  wire awake_st;
  wire blank_last;
  wire cfg_take;

  assign wake_any = wake_input_one | wake_input_two;
  assign stay_on = wake_any | core_supply_keep_on;
  // The comparator itself resolves the threshold against the level; zero means off.
  assign uv_hit = gate_supply_low_raw & (gate_supply_uv_level != `SERS_UV_OFF);
  assign in_reset_st = (state_q == ST_RESET);
  assign in_blank_st = (state_q == ST_BLANK);
  assign in_run_st = (state_q == ST_RUN);
  assign awake_st = in_blank_st | in_run_st;
  assign blank_last = (blank_cnt_q == `SERS_BLANK_LAST);
  // Writes are refused in reset and on the edge at which the chip drops back into it.
  assign cfg_take = awake_st & stay_on & cfg_wr;

  ////////////////////////////////////////////////////////////////////////////
  // Sequencing state machine.

  always @* begin
    state_d = state_q;
    case (state_q)
      ST_RESET: begin
        if (wake_any) begin
          state_d = ST_BLANK;
        end
      end
      ST_BLANK: begin
        if (!stay_on) begin
          state_d = ST_RESET;
        end else if (blank_last) begin
          state_d = ST_RUN;
        end
      end
      ST_RUN: begin
        if (!stay_on) begin
          state_d = ST_RESET;
        end
      end
      default: begin
        state_d = ST_RESET;
      end
    endcase
  end

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_q <= ST_RESET;
    end else if (clk_en) begin
      state_q <= state_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Undervoltage blanking window.

  // Counting cycles, not time, so the window scales with the oscillator. The count
  // holds at its last value so that a long stay in the run state cannot wrap it.
  always @* begin
    blank_cnt_d = blank_cnt_q;
    if (in_reset_st) begin
      blank_cnt_d = {`SERS_BLANK_W{1'b0}};
    end else if (in_blank_st && stay_on && !blank_last) begin
      blank_cnt_d = blank_cnt_q + 1'b1;
    end
  end

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      blank_cnt_q <= {`SERS_BLANK_W{1'b0}};
    end else if (clk_en) begin
      blank_cnt_q <= blank_cnt_d;
    end
  end

  always @* begin
    uv_blank_active_d = (state_d != ST_RUN);
  end

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      uv_blank_active <= 1'b1;
    end else if (clk_en) begin
      uv_blank_active <= uv_blank_active_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Core supply and chip reset.

  always @* begin
    chip_in_reset_d = (state_d == ST_RESET);
  end

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      chip_in_reset <= 1'b1;
    end else if (clk_en) begin
      chip_in_reset <= chip_in_reset_d;
    end
  end

  // The regulator follows the state directly, so it is never on while the chip is held.
  always @* begin
    core_supply_en_d = (state_d != ST_RESET);
  end

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      core_supply_en <= 1'b0;
    end else if (clk_en) begin
      core_supply_en <= core_supply_en_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Gate-drive undervoltage lockout and booster enable.

  // The flag also drops on the way into reset, so that it never outlives the gate
  // drive that it protects.
  always @* begin
    gate_supply_uv_d = 1'b0;
    if (in_run_st && stay_on) begin
      gate_supply_uv_d = uv_hit;
    end
  end

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      gate_supply_uv <= 1'b0;
    end else if (clk_en) begin
      gate_supply_uv <= gate_supply_uv_d;
    end
  end

  // During blanking the booster may run on an unproven gate supply; that is the price
  // of reaching normal mode before the supply has settled.
  always @* begin
    booster_run_d = 1'b0;
    if (awake_st && stay_on) begin
      if (in_run_st) begin
        booster_run_d = boost_en_q & ~uv_hit;
      end else begin
        booster_run_d = boost_en_q;
      end
    end
  end

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      booster_run <= 1'b0;
    end else if (clk_en) begin
      booster_run <= booster_run_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Software settings. Each is reloaded with its default on every edge spent in
  // reset, so that a wake always starts from a clean state.

  always @* begin
    level_d = gate_supply_level_sel;
    if (in_reset_st) begin
      level_d = `SERS_LEVEL_RST;
    end else if (cfg_take) begin
      level_d = cfg_level;
    end
  end

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      gate_supply_level_sel <= `SERS_LEVEL_RST;
    end else if (clk_en) begin
      gate_supply_level_sel <= level_d;
    end
  end

  always @* begin
    uv_level_d = gate_supply_uv_level;
    if (in_reset_st) begin
      uv_level_d = `SERS_UV_RST;
    end else if (cfg_take) begin
      uv_level_d = cfg_uv_level;
    end
  end

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      gate_supply_uv_level <= `SERS_UV_RST;
    end else if (clk_en) begin
      gate_supply_uv_level <= uv_level_d;
    end
  end

  always @* begin
    keep_on_d = core_supply_keep_on;
    if (in_reset_st) begin
      keep_on_d = 1'b0;
    end else if (cfg_take) begin
      keep_on_d = cfg_keep_on;
    end
  end

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      core_supply_keep_on <= 1'b0;
    end else if (clk_en) begin
      core_supply_keep_on <= keep_on_d;
    end
  end

  always @* begin
    boost_en_d = boost_en_q;
    if (in_reset_st) begin
      boost_en_d = 1'b0;
    end else if (cfg_take) begin
      boost_en_d = cfg_boost_en;
    end
  end

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      boost_en_q <= 1'b0;
    end else if (clk_en) begin
      boost_en_q <= boost_en_d;
    end
  end

  always @* begin
    target_d = boost_target_level;
    if (in_reset_st) begin
      target_d = `SERS_TARGET_RST;
    end else if (cfg_take) begin
      target_d = cfg_target;
    end
  end

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      boost_target_level <= `SERS_TARGET_RST;
    end else if (clk_en) begin
      boost_target_level <= target_d;
    end
  end

endmodule // sers_sequencer

// ==== tb/sers_sequencer_checker.sv ====
// Checker of supply, reset and lockout relations.
// Assumes one clock, reset by rst.
`timescale 1ns/1ps
module sers_sequencer_checker (input wire core_clk, rst, clk_en, wake_input_one,
  wake_input_two, chip_in_reset, core_supply_en, uv_blank_active, gate_supply_uv,
  booster_run, core_supply_keep_on, input wire [2:0] gate_supply_uv_level,
  input wire [6:0] boost_target_level);
  wire w = wake_input_one | wake_input_two, c = chip_in_reset, e = core_supply_en;
  wire u = gate_supply_uv, k = core_supply_keep_on, t = |gate_supply_uv_level, up = clk_en & ~c;
  wire z = ~|{t, boost_target_level, booster_run, k};
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // Guards on $past skip the edge at which a flag has only just moved.
  a_wake_starts: assert property (clk_en && c && w |=> e && !c) else $error("No start.");
  a_keep_holds: assert property (up && k |=> e && !c) else $error("Keep lost.");
  a_sleep_off: assert property (up && !w && !k |=> c && !e) else $error("Awake.");
  a_reset_clears: assert property (c && $past(c) |-> z) else $error("Kept.");
  a_run_awake: assert property (booster_run |-> !c) else $error("Runs.");
  a_blank_quiet: assert property (uv_blank_active |-> !u) else $error("Blank.");
  a_uv_stops: assert property (u |-> !booster_run) else $error("On.");
  a_zero_off: assert property (!t && !$past(t) |-> !u) else $error("Uv.");
endmodule // sers_sequencer_checker
bind sers_sequencer sers_sequencer_checker sers_sequencer_checker_i (.*);

// ==== tb/sers_host.sv ====
// Vehicle side: wake levels and one-cycle setting writes.
// Assumes the bench calls drive; changes land just after core_clk rises.
`timescale 1ns/1ps
module sers_host (input wire core_clk, output reg wake_input_one = 0, wake_input_two = 0,
  cfg_wr = 0, cfg_keep_on = 0, cfg_boost_en = 1, output reg [3:0] cfg_level = 0,
  output reg [2:0] cfg_uv_level = 0, output reg [6:0] cfg_target = 0);
  task drive(input [17:0] v);
    @(posedge core_clk) {cfg_wr, wake_input_one, wake_input_two, cfg_keep_on, cfg_uv_level,
      cfg_level, cfg_target} <= v;
    @(posedge core_clk) cfg_wr <= 0;
  endtask
endmodule // sers_host

// ==== tb/sers_sequencer_tb.sv ====
// Bench: wake, settings, blanking, lockout, keep-on and sleep.
// Assumes sers_host on the vehicle side and the bound checker.
`timescale 1ns/1ps
`include "sers_consts.vh"
module sers_sequencer_tb;
  reg core_clk = 0, rst = 1, clk_en = 1, gate_supply_low_raw = 0;
  wire wake_input_one, wake_input_two, cfg_wr, cfg_keep_on, cfg_boost_en, core_supply_en;
  wire chip_in_reset, uv_blank_active, gate_supply_uv, booster_run, core_supply_keep_on;
  wire [3:0] cfg_level, gate_supply_level_sel;
  wire [2:0] cfg_uv_level, gate_supply_uv_level;
  wire [6:0] cfg_target, boost_target_level;
  wire [14:0] s = {core_supply_keep_on, gate_supply_uv_level, gate_supply_level_sel,
    boost_target_level};
  integer n_fail = 0, checks_done = 0, seed = 32'h07c6, i;
  reg [14:0] q[$], p = 0, v;
  initial forever #5 core_clk = ~core_clk;
  sers_host host_i (.*);
  sers_sequencer sers_sequencer_i (.*);
  task t(input integer n); repeat (n) @(posedge core_clk); endtask
  task chk(input [14:0] a, b);
    checks_done++;
    if (a !== b) begin n_fail++; $display("ERROR %0t got %h want %h", $time, a, b); end
  endtask
  task complete_run;
    $display("checks %0d fails %0d", checks_done, n_fail);
    if (!n_fail && checks_done) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge core_clk) if (!rst && s !== p) begin p <= s; chk(s, q.pop_front()); end
  initial #300000 begin n_fail++; complete_run; end
  initial begin
    t(6); rst <= 0;
    host_i.drive({3'b001, 15'h0}); t(1);
    chk(core_supply_en, 1);
    gate_supply_low_raw <= 1;
    for (i = 1; i < 4; i++) begin
      v = $random(seed); v = {2'b11, v[12], 1'b1, v[10:7], i[6:0]};
      q.push_back(v); host_i.drive({3'b101, v});
    end
    t(`SERS_BLANK_CYC - 40);
    chk({uv_blank_active, gate_supply_uv, booster_run}, 3'b101);
    t(60);
    chk({uv_blank_active, gate_supply_uv, booster_run}, 3'b010);
    v[13:11] = 0; q.push_back(v); host_i.drive({3'b101, v}); t(3);
    chk({gate_supply_uv, booster_run}, 1);
    host_i.drive({3'b000, v}); t(3);
    chk({chip_in_reset, core_supply_en}, 1);
    v[14] = 0; q.push_back(v); q.push_back(0); host_i.drive({3'b100, v}); t(3);
    chk({chip_in_reset, core_supply_en, booster_run}, 3'b100);
    clk_en <= 0; host_i.drive({3'b010, v}); t(2);
    chk(chip_in_reset, 1);
    clk_en <= 1; t(3);
    chk(core_supply_en, 1);
    rst <= 1; t(2);
    chk({chip_in_reset, core_supply_en, uv_blank_active}, 3'b101);
    rst <= 0; t(3);
    chk({core_supply_en, booster_run, uv_blank_active}, 3'b101);
    chk(q.size(), 0);
    complete_run;
  end
endmodule // sers_sequencer_tb
